// ### verilog/fsq_cfg.svh
/*
  Constants of the flash row program sequencer: register offsets, field positions, reset values, sizes.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef FSQ_CFG_SVH
`define FSQ_CFG_SVH

`define FSQ_ADDR_W 16
`define FSQ_DATA_W 24
`define FSQ_ROW_WORDS 32
`define FSQ_ROW_BYTES 96
`define FSQ_IDX_W 5
`define FSQ_TBLWR_CYCLES 2

`define FSQ_OFF_CTRL 12'h000
`define FSQ_OFF_KEY 12'h004
`define FSQ_OFF_TADDR 12'h008
`define FSQ_OFF_TDATA 12'h00c
`define FSQ_OFF_STAT 12'h010
`define FSQ_OFF_LOADED 12'h014

`define FSQ_CTRL_START 15
`define FSQ_CTRL_WREN 14
`define FSQ_CTRL_MEM 6
`define FSQ_CTRL_OP_LO 0
`define FSQ_CTRL_OP_HI 2
`define FSQ_CTRL_RST 16'h0000

`define FSQ_STAT_DONE 0
`define FSQ_STAT_BUSY 1
`define FSQ_STAT_ARMED 2

`define FSQ_KEY_FIRST 8'h55
`define FSQ_KEY_SECOND 8'haa
`define FSQ_LATCH_RST 24'hffffff

`endif

// ### verilog/fsq_pkg.sv
/*
  Types of the flash row program sequencer.
  Assumes fsq_cfg.svh on the include path.
*/
`include "fsq_cfg.svh"
package fsq_pkg;
  typedef enum logic [2:0] {
    FSQ_OP_ERASE1 = 3'b000,
    FSQ_OP_ERASE2 = 3'b001,
    FSQ_OP_ERASE4 = 3'b010,
    FSQ_OP_PROG_ROW = 3'b011,
    FSQ_OP_PROG_WORD = 3'b100
  } fsq_op_t;

  typedef enum logic [1:0] {
    FSQ_KEY_NONE = 2'b00,
    FSQ_KEY_HALF = 2'b01,
    FSQ_KEY_ARMED = 2'b10
  } fsq_key_t;

  typedef enum logic [2:0] {
    FSQ_ST_IDLE = 3'b000,
    FSQ_ST_ERASE = 3'b001,
    FSQ_ST_SCAN = 3'b010,
    FSQ_ST_PROG = 3'b011,
    FSQ_ST_FINISH = 3'b100
  } fsq_state_t;

  typedef enum logic {
    FSQ_CMD_ERASE = 1'b0,
    FSQ_CMD_PROG = 1'b1
  } fsq_cmd_t;

  // One request to the flash macro
  typedef struct packed {
    fsq_cmd_t cmd;
    logic mem_sel;
    logic [`FSQ_ADDR_W-1:0] addr;
    logic [7:0] words;
    logic [`FSQ_DATA_W-1:0] data;
  } fsq_flash_req_t;
endpackage : fsq_pkg

// ### verilog/fsq_latch_bank.sv
/*
  Row-wide holding latches with a per-entry loaded mark.
  Assumes one synchronous write port and one combinational read port.
*/
`timescale 1ns/1ps
`include "fsq_cfg.svh"
module fsq_latch_bank
  import fsq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Load port
  input wire logic wr_en,
  input wire logic [`FSQ_IDX_W-1:0] wr_idx,
  input wire logic [`FSQ_DATA_W-1:0] wr_data,
  input wire logic clear_loaded,
  // Read port
  input wire logic [`FSQ_IDX_W-1:0] rd_idx,
  output logic [`FSQ_DATA_W-1:0] rd_data,
  output logic [`FSQ_ROW_WORDS-1:0] loaded
);
  logic [`FSQ_DATA_W-1:0] latch_mem [`FSQ_ROW_WORDS];

  for (genvar i = 0; i < `FSQ_ROW_WORDS; i++) begin : g_entry
    // Any order, any number of rewrites; the last one stays
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        latch_mem[i] <= `FSQ_LATCH_RST;
      end else if (wr_en && wr_idx == `FSQ_IDX_W'(i)) begin
        latch_mem[i] <= wr_data;
      end
    end

    // A load in the clearing cycle is kept so it is not lost
    logic loaded_reg;

    always_ff @(posedge clk) begin
      if (!rst_b) begin
        loaded_reg <= 1'b0;
      end else if (wr_en && wr_idx == `FSQ_IDX_W'(i)) begin
        loaded_reg <= 1'b1;
      end else if (clear_loaded) begin
        loaded_reg <= 1'b0;
      end
    end

    assign loaded[i] = loaded_reg;
  end

  assign rd_data = latch_mem[rd_idx];
endmodule : fsq_latch_bank

// ### verilog/fsq_sequencer.sv
/*
  Flash row program sequencer: APB register slave, unlock key, holding latches and
  the erase/program walk towards the flash macro.
  Assumes an APB master on clk and a flash macro that answers each request with a one-cycle ack.
*/
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "fsq_cfg.svh"
module fsq_sequencer
  import fsq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash macro
  output logic flash_req,
  output fsq_flash_req_t flash_cmd,
  input wire logic flash_ack,
  // Core
  output logic cpu_stall,
  output logic flash_done_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic access;
  logic hit_ctrl, hit_key, hit_taddr, hit_tdata, hit_stat, hit_loaded, hit_any;
  logic busy;
  logic tbl_wait_reg;
  logic wr_done;

  assign access = psel && penable;
  assign hit_ctrl = paddr == `FSQ_OFF_CTRL;
  assign hit_key = paddr == `FSQ_OFF_KEY;
  assign hit_taddr = paddr == `FSQ_OFF_TADDR;
  assign hit_tdata = paddr == `FSQ_OFF_TDATA;
  assign hit_stat = paddr == `FSQ_OFF_STAT;
  assign hit_loaded = paddr == `FSQ_OFF_LOADED;
  assign hit_any = hit_ctrl | hit_key | hit_taddr | hit_tdata | hit_stat | hit_loaded;

  // Core is held off the bus for the whole operation
  assign cpu_stall = busy;
  // Table data writes get one wait state
  assign pready = !busy && !(pwrite && hit_tdata && !tbl_wait_reg);
  assign pslverr = access && pready && !hit_any;
  assign wr_done = access && pready && pwrite && hit_any;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tbl_wait_reg <= 1'b0;
    end else begin
      tbl_wait_reg <= access && pwrite && hit_tdata && !busy && !tbl_wait_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unlock key

  fsq_key_t key_reg;
  logic start_req;
  logic start_ok;

  assign start_req = wr_done && hit_ctrl && pwdata[`FSQ_CTRL_START];
  // Start needs the armed key and the enable bit in the same write
  assign start_ok = start_req && key_reg == FSQ_KEY_ARMED && pwdata[`FSQ_CTRL_WREN];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      key_reg <= FSQ_KEY_NONE;
    end else if (wr_done && hit_key) begin
      if (key_reg == FSQ_KEY_NONE && pwdata[7:0] == `FSQ_KEY_FIRST) begin
        key_reg <= FSQ_KEY_HALF;
      end else if (key_reg == FSQ_KEY_HALF && pwdata[7:0] == `FSQ_KEY_SECOND) begin
        key_reg <= FSQ_KEY_ARMED;
      end else begin
        key_reg <= FSQ_KEY_NONE;
      end
    end else if (wr_done) begin
      // Any other write to a mapped register spends or breaks the unlock; unmapped writes leave it
      key_reg <= FSQ_KEY_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and table address

  logic [15:0] ctrl_reg;
  logic [`FSQ_ADDR_W-1:0] taddr_reg;
  fsq_state_t state_reg;
  logic finish;

  assign finish = state_reg == FSQ_ST_FINISH;
  assign busy = state_reg != FSQ_ST_IDLE;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_reg <= `FSQ_CTRL_RST;
    end else if (finish) begin
      ctrl_reg[`FSQ_CTRL_START] <= 1'b0;
    end else if (wr_done && hit_ctrl) begin
      ctrl_reg <= pwdata[15:0];
      ctrl_reg[`FSQ_CTRL_START] <= start_ok;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      taddr_reg <= '0;
    end else if (wr_done && hit_taddr) begin
      taddr_reg <= pwdata[`FSQ_ADDR_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holding latches

  logic [`FSQ_IDX_W-1:0] idx_reg;
  logic [`FSQ_DATA_W-1:0] latch_rd;
  logic [`FSQ_ROW_WORDS-1:0] loaded;
  logic row_prog_end;

  // The low address bits pick the latch; the array is not touched here
  fsq_latch_bank u_latch (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(wr_done && hit_tdata),
    .wr_idx(taddr_reg[`FSQ_IDX_W-1:0]),
    .wr_data(pwdata[`FSQ_DATA_W-1:0]),
    .clear_loaded(row_prog_end),
    .rd_idx(idx_reg),
    .rd_data(latch_rd),
    .loaded(loaded)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operation walk

  fsq_op_t op;
  logic [`FSQ_ADDR_W-1:0] blk_mask;
  logic [7:0] blk_words;

  assign op = fsq_op_t'(ctrl_reg[`FSQ_CTRL_OP_HI:`FSQ_CTRL_OP_LO]);
  assign row_prog_end = finish && op == FSQ_OP_PROG_ROW;

  always_comb begin
    case (op)
      FSQ_OP_ERASE2: blk_words = 8'd64;
      FSQ_OP_ERASE4: blk_words = 8'd128;
      default: blk_words = 8'(`FSQ_ROW_WORDS);
    endcase
    blk_mask = ~(`FSQ_ADDR_W'(blk_words) - `FSQ_ADDR_W'(1));
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= FSQ_ST_IDLE;
      idx_reg <= '0;
    end else begin
      case (state_reg)
        FSQ_ST_IDLE: begin
          idx_reg <= '0;
          if (start_ok) begin
            case (fsq_op_t'(pwdata[`FSQ_CTRL_OP_HI:`FSQ_CTRL_OP_LO]))
              FSQ_OP_ERASE1, FSQ_OP_ERASE2, FSQ_OP_ERASE4: state_reg <= FSQ_ST_ERASE;
              FSQ_OP_PROG_ROW: state_reg <= FSQ_ST_SCAN;
              FSQ_OP_PROG_WORD: begin
                // The word's own latch is read out
                idx_reg <= taddr_reg[`FSQ_IDX_W-1:0];
                state_reg <= FSQ_ST_PROG;
              end
              default: state_reg <= FSQ_ST_FINISH;
            endcase
          end
        end
        FSQ_ST_ERASE: begin
          if (flash_ack) begin
            state_reg <= FSQ_ST_FINISH;
          end
        end
        FSQ_ST_SCAN: begin
          // Unloaded latches are skipped, so a partial row still completes
          if (loaded[idx_reg]) begin
            state_reg <= FSQ_ST_PROG;
          end else if (idx_reg == `FSQ_IDX_W'(`FSQ_ROW_WORDS - 1)) begin
            state_reg <= FSQ_ST_FINISH;
          end else begin
            idx_reg <= idx_reg + `FSQ_IDX_W'(1);
          end
        end
        FSQ_ST_PROG: begin
          if (flash_ack) begin
            if (op != FSQ_OP_PROG_ROW || idx_reg == `FSQ_IDX_W'(`FSQ_ROW_WORDS - 1)) begin
              state_reg <= FSQ_ST_FINISH;
            end else begin
              idx_reg <= idx_reg + `FSQ_IDX_W'(1);
              state_reg <= FSQ_ST_SCAN;
            end
          end
        end
        FSQ_ST_FINISH: state_reg <= FSQ_ST_IDLE;
        default: state_reg <= FSQ_ST_IDLE;
      endcase
    end
  end

  // Request to the flash macro, registered
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flash_req <= 1'b0;
      flash_cmd <= '0;
    end else begin
      flash_req <= (state_reg == FSQ_ST_ERASE || state_reg == FSQ_ST_PROG) && !flash_ack;
      flash_cmd.mem_sel <= ctrl_reg[`FSQ_CTRL_MEM];
      if (state_reg == FSQ_ST_ERASE) begin
        flash_cmd.cmd <= FSQ_CMD_ERASE;
        flash_cmd.addr <= taddr_reg & blk_mask;
        flash_cmd.words <= blk_words;
        flash_cmd.data <= '0;
      end else if (state_reg == FSQ_ST_PROG && op == FSQ_OP_PROG_ROW) begin
        flash_cmd.cmd <= FSQ_CMD_PROG;
        flash_cmd.addr <= (taddr_reg & blk_mask) | `FSQ_ADDR_W'(idx_reg);
        flash_cmd.words <= 8'd1;
        flash_cmd.data <= latch_rd;
      end else if (state_reg == FSQ_ST_PROG) begin
        flash_cmd.cmd <= FSQ_CMD_PROG;
        flash_cmd.addr <= taddr_reg;
        flash_cmd.words <= 8'd1;
        flash_cmd.data <= loaded[taddr_reg[`FSQ_IDX_W-1:0]] ? u_latch_word(taddr_reg) : `FSQ_LATCH_RST;
      end
    end
  end

  // Single-word program takes the latch addressed by the table pointer if it is marked loaded, otherwise all ones
  function automatic logic [`FSQ_DATA_W-1:0] u_latch_word(input logic [`FSQ_ADDR_W-1:0] a);
    u_latch_word = (a[`FSQ_IDX_W-1:0] == idx_reg) ? latch_rd : `FSQ_LATCH_RST;
  endfunction : u_latch_word

  ////////////////////////////////////////////////////////////////////////////
  // Read views

  // Read data is loaded one edge before the master takes it, so a read held
  // off by an operation is loaded in its last cycle; the views already show
  // the values that stand after that cycle, so polled status is never stale.
  logic [15:0] ctrl_view;
  logic [2:0] stat_view;
  logic [`FSQ_ROW_WORDS-1:0] loaded_view;

  always_comb begin
    ctrl_view = ctrl_reg;
    loaded_view = loaded;
    stat_view = '0;
    if (finish) begin
      ctrl_view[`FSQ_CTRL_START] = 1'b0;
    end
    if (row_prog_end) begin
      loaded_view = '0;
    end
    stat_view[`FSQ_STAT_DONE] = flash_done_flag || finish;
    stat_view[`FSQ_STAT_BUSY] = busy && !finish;
    stat_view[`FSQ_STAT_ARMED] = key_reg == FSQ_KEY_ARMED;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Done flag and read data

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flash_done_flag <= 1'b0;
    end else if (finish) begin
      flash_done_flag <= 1'b1;
    end else if (wr_done && hit_stat && pwdata[`FSQ_STAT_DONE]) begin
      flash_done_flag <= 1'b0;
    end
  end

  // Key register reads as zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (psel && !pwrite) begin
      prdata <= '0;
      if (hit_ctrl) begin
        prdata[15:0] <= ctrl_view;
      end else if (hit_taddr) begin
        prdata[`FSQ_ADDR_W-1:0] <= taddr_reg;
      end else if (hit_stat) begin
        prdata[2:0] <= stat_view;
      end else if (hit_loaded) begin
        prdata <= loaded_view;
      end
    end
  end
endmodule : fsq_sequencer

// ### tb/fsq_sequencer_assertions.sv
/*
  Port checker of fsq_sequencer.
  Assumes fsq_cfg.svh on the include path; attached to every fsq_sequencer by bind.
*/
`timescale 1ns/1ps
`include "fsq_cfg.svh"
module fsq_sequencer_checker
  import fsq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flash macro and core
  input wire logic flash_req,
  input wire fsq_flash_req_t flash_cmd,
  input wire logic flash_ack,
  input wire logic cpu_stall,
  input wire logic flash_done_flag
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire logic acc = psel && penable && pready;
  wire logic done_clr = acc && pwrite && paddr == `FSQ_OFF_STAT && pwdata[0];
  ////////////////////////////////////////////////////////////////////////
  a_req_under_stall: assert property (flash_req |-> cpu_stall)
    else $error("flash request outside stall");
  a_stall_blocks_bus: assert property (cpu_stall && psel && penable |-> !pready)
    else $error("bus answered during operation");
  a_req_stands: assert property (flash_req && !flash_ack |=> flash_req && $stable(flash_cmd))
    else $error("flash request changed before ack");
  a_req_drops: assert property (flash_ack |=> !flash_req)
    else $error("flash request kept after ack");
  a_erase_aligned: assert property (flash_req && flash_cmd.cmd == FSQ_CMD_ERASE |->
    flash_cmd.words inside {8'h20, 8'h40, 8'h80} && flash_cmd.addr[4:0] == 5'h00 &&
    (flash_cmd.words != 8'h40 || flash_cmd.addr[5] == 1'b0) &&
    (flash_cmd.words != 8'h80 || flash_cmd.addr[6:5] == 2'b00))
    else $error("erase block size or alignment wrong");
  a_prog_single: assert property (flash_req && flash_cmd.cmd == FSQ_CMD_PROG |-> flash_cmd.words == 8'h01)
    else $error("program request not one word");
  a_done_on_end: assert property ($fell(cpu_stall) |-> flash_done_flag)
    else $error("operation ended without done flag");
  a_done_sticky: assert property (flash_done_flag && !done_clr |=> flash_done_flag)
    else $error("done flag lost without clear");
  a_tdata_wait: assert property (psel && $rose(penable) && pwrite && paddr == `FSQ_OFF_TDATA |->
    !pready ##1 (pready || cpu_stall))
    else $error("latch load not two cycles");
  a_unmapped_err: assert property (acc && paddr >= 12'h018 |-> pslverr)
    else $error("unmapped access without error");
endmodule : fsq_sequencer_checker

bind fsq_sequencer fsq_sequencer_checker u_chk (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .flash_req, .flash_cmd, .flash_ack, .cpu_stall, .flash_done_flag);

// ### tb/fsq_flash_model.sv
/*
  Behavioural flash macro: acks each request after ack_delay cycles and logs it.
  Assumes the sequencer holds flash_req until the cycle after the ack.
*/
`timescale 1ns/1ps
module fsq_flash_model
  import fsq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Flash macro side
  input wire logic flash_req,
  input wire fsq_flash_req_t flash_cmd,
  input wire logic [3:0] ack_delay,
  output logic flash_ack
);
  fsq_flash_req_t req_log[$];
  logic [3:0] cnt;
  // Ack is a one-cycle pulse, low at least a cycle between requests
  always @(posedge clk) begin
    if (!rst_b) begin
      flash_ack <= 1'b0;
      cnt <= 4'h0;
    end else if (flash_ack) begin
      flash_ack <= 1'b0;
      cnt <= 4'h0;
    end else if (flash_req) begin
      if (cnt >= ack_delay) begin
        flash_ack <= 1'b1;
        req_log.push_back(flash_cmd);
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : fsq_flash_model

// ### tb/test_flash_row_program_sequencer.sv
/*
  Self-checking bench of fsq_sequencer over APB with a flash macro model.
  Assumes fsq_cfg.svh on the include path and the checker bound in.
*/
`timescale 1ns/1ps
`include "fsq_cfg.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_flash_row_program_sequencer
  import fsq_pkg::*;
;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, flash_req, flash_ack, cpu_stall, flash_done_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] ack_delay;
  fsq_flash_req_t flash_cmd;
  int num_errors, total_checks;
  fsq_sequencer dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .flash_req, .flash_cmd, .flash_ack, .cpu_stall, .flash_done_flag);
  fsq_flash_model model (.clk, .rst_b, .flash_req, .flash_cmd, .ack_delay, .flash_ack);
  ////////////////////////////////////////////////////////////////////////
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 500);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      end_sim;
    end
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd
  task go(input logic [31:0] ctrl);
    wr(`FSQ_OFF_KEY, 32'h55);
    wr(`FSQ_OFF_KEY, 32'haa);
    wr(`FSQ_OFF_CTRL, ctrl);
  endtask : go
  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    logic [31:0] r;
    logic e;
    rd(`FSQ_OFF_STAT, r); `CHK("stat", 32'h0, r)
    rd(`FSQ_OFF_KEY, r); `CHK("key", 32'h0, r)
    apb(1'b0, 12'h018, 32'h0, r, e); `CHK("unmapped", 1'b1, e)
  endtask : t_reset
  task t_row;
    logic [31:0] r;
    int b;
    b = model.req_log.size();
    wr(`FSQ_OFF_TADDR, 32'h43); wr(`FSQ_OFF_TDATA, 32'h111111);
    wr(`FSQ_OFF_TADDR, 32'h41); wr(`FSQ_OFF_TDATA, 32'h222222);
    wr(`FSQ_OFF_TADDR, 32'h43); wr(`FSQ_OFF_TDATA, 32'h333333);
    rd(`FSQ_OFF_LOADED, r); `CHK("loaded", 32'h0000000a, r)
    `CHK("no early write", b, model.req_log.size())
    ack_delay <= 4'h3;
    go(32'h0000c003);
    rd(`FSQ_OFF_STAT, r); `CHK("done", 2'b01, r[1:0])
    rd(`FSQ_OFF_CTRL, r); `CHK("start", 1'b0, r[15])
    `CHK("row reqs", b + 2, model.req_log.size())
    `CHK("row w1", fsq_flash_req_t'{FSQ_CMD_PROG, 1'b0, 16'h0041, 8'h01, 24'h222222}, model.req_log[b])
    `CHK("row w3", fsq_flash_req_t'{FSQ_CMD_PROG, 1'b0, 16'h0043, 8'h01, 24'h333333}, model.req_log[b+1])
    rd(`FSQ_OFF_LOADED, r); `CHK("loaded clr", 32'h0, r)
    wr(`FSQ_OFF_STAT, 32'h1);
  endtask : t_row
  task t_erase;
    logic [31:0] r;
    fsq_flash_req_t q;
    logic [7:0] w;
    ack_delay <= 4'h0;
    for (int i = 0; i < 3; i++) begin
      w = 8'h20 << i;
      wr(`FSQ_OFF_TADDR, 32'he5);
      go(32'h0000c000 | i);
      rd(`FSQ_OFF_STAT, r);
      q = model.req_log[model.req_log.size()-1];
      `CHK("erase", {FSQ_CMD_ERASE, 16'h00e5 & ~{8'h00, w - 8'h01}, w}, {q.cmd, q.addr, q.words})
    end
    wr(`FSQ_OFF_STAT, 32'h1);
  endtask : t_erase
  task t_refuse;
    logic [31:0] r;
    int b;
    b = model.req_log.size();
    wr(`FSQ_OFF_KEY, 32'h55); wr(`FSQ_OFF_TADDR, 32'h0); wr(`FSQ_OFF_KEY, 32'haa); wr(`FSQ_OFF_CTRL, 32'hc000);
    wr(`FSQ_OFF_KEY, 32'h55); wr(`FSQ_OFF_KEY, 32'h12); wr(`FSQ_OFF_CTRL, 32'hc000);
    wr(`FSQ_OFF_CTRL, 32'hc000);
    go(32'h00008000);
    rd(`FSQ_OFF_CTRL, r); `CHK("no start", 1'b0, r[15])
    rd(`FSQ_OFF_STAT, r); `CHK("no done", 1'b0, r[0])
    `CHK("no reqs", b, model.req_log.size())
  endtask : t_refuse
  task t_word;
    logic [31:0] r;
    ack_delay <= 4'h5;
    wr(`FSQ_OFF_TADDR, 32'h105); wr(`FSQ_OFF_TDATA, 32'h0abcde);
    go(32'h0000c044);
    rd(`FSQ_OFF_STAT, r); `CHK("word done", 1'b1, r[0])
    `CHK("done pin", 1'b1, flash_done_flag)
    `CHK("word", fsq_flash_req_t'{FSQ_CMD_PROG, 1'b1, 16'h0105, 8'h01, 24'h0abcde}, model.req_log[$])
  endtask : t_word
  task end_sim;
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim;
  end
  initial begin
    {rst_b, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ack_delay = 4'h0;
    num_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_row;
    t_erase;
    t_refuse;
    t_word;
    end_sim;
  end
endmodule : test_flash_row_program_sequencer
